// ### rtl/pic_pkg.sv
// Constants for the priority interrupt controller: register map, field
// positions, source numbering, vector table and machine-cycle timing.
// Assumes a single 250 MHz core clock shared with the processor.
`default_nettype none

package pic_pkg;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TIMER_CONTROL  = 8'h88;
	localparam logic [7:0] IDX_EDGE_FLAGS     = 8'h91;
	localparam logic [7:0] IDX_SERIAL_FLAGS   = 8'h98;
	localparam logic [7:0] IDX_BASE_ENABLE    = 8'ha8;
	localparam logic [7:0] IDX_BASE_PRIORITY  = 8'hb8;
	localparam logic [7:0] IDX_SERVICE_STATUS = 8'hc0;
	localparam logic [7:0] IDX_WATCHDOG_FLAGS = 8'hd8;
	localparam logic [7:0] IDX_EXT_ENABLE     = 8'he8;
	localparam logic [7:0] IDX_EXT_PRIORITY   = 8'hf8;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;

	// ==========================================================
	// Field positions
	localparam int TC_EXT0_MODE = 0;
	localparam int TC_EXT0_FLAG = 1;
	localparam int TC_EXT1_MODE = 2;
	localparam int TC_EXT1_FLAG = 3;
	localparam int TC_TMR0_FLAG = 5;
	localparam int TC_TMR1_FLAG = 7;
	localparam int SER_RX_FLAG  = 0;
	localparam int SER_TX_FLAG  = 1;
	localparam int WD_FLAG      = 3;
	localparam int GLOBAL_GATE  = 7;
	localparam int EDGE_LSB     = 4;
	localparam int PRIO_FIELD_W = 5;
	localparam logic [7:0] EXT_PRIO_ONES    = 8'he0;
	localparam logic [7:0] EDGE_RSVD_ONES   = 8'h08;
	localparam logic [7:0] PRIO_RESET       = 8'h00;

	// ==========================================================
	// Sources in natural polling order
	localparam int NSRC      = 10;
	localparam int SRC_EXT0  = 0;
	localparam int SRC_TMR0  = 1;
	localparam int SRC_EXT1  = 2;
	localparam int SRC_TMR1  = 3;
	localparam int SRC_SER0  = 4;
	localparam int SRC_EXT2  = 5;
	localparam int SRC_WDOG  = 9;
	localparam int NPINS     = 6;

	localparam logic [15:0] AUX_VECTOR = 16'h0033;
	localparam logic [NSRC*16-1:0] VECTOR_TABLE = {
		16'h0063, 16'h005b, 16'h0053, 16'h004b, 16'h0043,
		16'h0023, 16'h001b, 16'h0013, 16'h000b, 16'h0003};

	// Pins sampled once per machine cycle of eight clocks
	localparam int MACHINE_CYCLE_CLKS = 8;
	localparam int MC_CNT_W           = 3;

	typedef enum logic [1:0] {
		PIC_LVL_LOW,
		PIC_LVL_HIGH,
		PIC_LVL_AUX
	} pic_level_e;

endpackage : pic_pkg

`default_nettype wire

// ### rtl/pic_pin_sampler.sv
// Samples the six external request pins once per machine cycle and
// reports sampled level plus rising and falling edges between samples.
// Assumes pins already synchronous to ref_clk_in.
`default_nettype none

module pic_pin_sampler (
	input  wire logic                    ref_clk_in,  // Core clock
	input  wire logic                    rst_in,      // Async reset, high
	input  wire logic [pic_pkg::NPINS-1:0] pins_in,   // Raw pin levels
	output logic      [pic_pkg::NPINS-1:0] level_out, // Sampled level
	output logic      [pic_pkg::NPINS-1:0] rise_out,  // Rising edge pulse
	output logic      [pic_pkg::NPINS-1:0] fall_out   // Falling edge pulse
);

	logic [pic_pkg::MC_CNT_W-1:0] mc_cnt_q;
	logic                         strobe;

	// ==========================================================
	// Machine cycle strobe
	assign strobe = (mc_cnt_q == pic_pkg::MC_CNT_W'(pic_pkg::MACHINE_CYCLE_CLKS - 1));

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mc_cnt_q <= '0;
		end else begin
			mc_cnt_q <= strobe ? '0 : mc_cnt_q + 1'b1;
		end
	end

	// ==========================================================
	// Per-pin sample and edge compare
	genvar i;
	generate
		for (i = 0; i < pic_pkg::NPINS; i++) begin : g_pin
			logic prev_q;
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					level_out[i] <= 1'b1;
					prev_q       <= 1'b1;
					rise_out[i]  <= 1'b0;
					fall_out[i]  <= 1'b0;
				end else begin
					rise_out[i] <= strobe && !prev_q && pins_in[i];
					fall_out[i] <= strobe && prev_q && !pins_in[i];
					if (strobe) begin
						prev_q       <= pins_in[i];
						level_out[i] <= pins_in[i];
					end
				end
			end
		end
	endgenerate

endmodule : pic_pin_sampler

`default_nettype wire

// ### rtl/pic_controller.sv
// Three-level priority interrupt controller for an 8-bit core: polling,
// nesting, stack push/pop sequencing, vectoring and register file.
// Assumes the core stalls while busy_out is high and that the stack port
// returns pop data in the same cycle as the pop strobe.
//
// How it works
// - Requests are judged only on the instruction-boundary strobe.
// - Equal-level simultaneous requests go in fixed polling order, external 0 first.
// - Top level belongs only to the auxiliary request, vector 0033 hex.
// - Every other source has one priority bit, high or low.
// - Base priority: bit4 serial0, bit3 timer1, bit2 ext1, bit1 timer0, bit0 ext0.
// - Extended priority: bit4 watchdog, bits 3..0 external 5..2.
// - Extended priority bits 7..5 always read as one.
// - Nothing preempts a running auxiliary handler.
// - Only auxiliary preempts a high-level handler.
// - A high-level request may preempt a low-level handler.
// - Low-level requests are taken only with nothing in service.
// - Higher level first, then earliest in polling order.
// - Accept pushes PC low then high, then jumps to the vector.
// - Accept blocks same and lower levels until the matching return.
// - Timer and external pending flags clear on acceptance.
// - Return pops PC high then low and restores prior service state.
// - Serial request follows receive or transmit flag; software clears them.
// - Pins 0 and 1 active low; mode 0 level, mode 1 falling edge.
// - Pins sampled once per machine cycle; edges need one cycle each side.
// - Pins 2 and 4 rising edge only, 3 and 5 falling edge only.
// - Edges on pins 2..5 set sticky flags in the edge flag register.
// - Global gate bit 7 of base enable gates every non-auxiliary request.
// - Level mode flag follows the pin; edge mode flag clears on vector.
`default_nettype none

module pic_controller (
	input  wire logic                       ref_clk_in,            // Core clock
	input  wire logic                       rst_in,                // Async reset, high
	input  wire logic [pic_pkg::ADDR_W-1:0] avs_address_in,        // Byte address
	input  wire logic                       avs_read_in,           // Read request
	input  wire logic                       avs_write_in,          // Write request
	input  wire logic [pic_pkg::DATA_W-1:0] avs_writedata_in,      // Write data
	input  wire logic [3:0]                 avs_byteenable_in,     // Byte lanes
	output logic      [pic_pkg::DATA_W-1:0] avs_readdata_out,      // Read data
	output logic                            avs_waitrequest_out,   // Stall
	input  wire logic [pic_pkg::NPINS-1:0]  ext_request_pin_in,    // Pins 0..5
	input  wire logic                       timer0_overflow_in,    // Pulse
	input  wire logic                       timer1_overflow_in,    // Pulse
	input  wire logic                       serial_receive_set_in, // Pulse
	input  wire logic                       serial_transmit_set_in,// Pulse
	input  wire logic                       watchdog_event_in,     // Pulse
	input  wire logic                       aux_request_in,        // Level
	input  wire logic                       instr_boundary_in,     // Pulse
	input  wire logic                       return_instr_in,       // Pulse
	input  wire logic [15:0]                pc_in,                 // Next PC
	output logic                            busy_out,              // Core stall
	output logic                            stack_push_out,        // Push strobe
	output logic                            stack_pop_out,         // Pop strobe
	output logic      [7:0]                 stack_push_data_out,   // Push byte
	input  wire logic [7:0]                 stack_pop_data_in,     // Pop byte
	output logic                            pc_load_out,           // PC load strobe
	output logic      [15:0]                pc_load_value_out      // New PC
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_PUSH_LO, ST_PUSH_HI, ST_VECTOR, ST_POP_HI, ST_POP_LO, ST_RESUME
	} pic_state_e;

	pic_state_e state_q;
	logic [7:0] timer_control_register_q, edge_q, ser_q, wdog_q, ben_q, bprio_q, een_q, eprio_q;
	logic [2:0] insvc_q;
	logic [15:0] pc_q;
	logic [pic_pkg::NSRC-1:0] clr_src_q;
	logic ack_q;
	logic [pic_pkg::NPINS-1:0] pin_lvl, pin_rise, pin_fall;

	// ==========================================================
	// Pin sampling
	pic_pin_sampler u_sampler (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.pins_in    (ext_request_pin_in),
		.level_out  (pin_lvl),
		.rise_out   (pin_rise),
		.fall_out   (pin_fall)
	);

	// ==========================================================
	// Avalon slave: one wait cycle, then answer
	logic       req;
	logic [7:0] idx;
	logic       aligned;
	logic       wr_go;
	logic [7:0] wdat;
	logic [7:0] rd_mux;

	assign req                 = avs_read_in || avs_write_in;
	assign avs_waitrequest_out = req && !ack_q;
	assign idx                 = avs_address_in[pic_pkg::ADDR_W-1:2];
	assign aligned             = (avs_address_in[1:0] == 2'b00);
	assign wr_go               = avs_write_in && ack_q && aligned && avs_byteenable_in[0];
	assign wdat                = avs_writedata_in[7:0];

	function automatic logic wr_hit(input logic [7:0] target);
		wr_hit = wr_go && (idx == target);
	endfunction : wr_hit

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		if (aligned) begin
			unique case (idx)
				pic_pkg::IDX_TIMER_CONTROL:  rd_mux = timer_control_register_q;
				pic_pkg::IDX_EDGE_FLAGS:     rd_mux = edge_q | pic_pkg::EDGE_RSVD_ONES;
				pic_pkg::IDX_SERIAL_FLAGS:   rd_mux = ser_q;
				pic_pkg::IDX_BASE_ENABLE:    rd_mux = ben_q;
				pic_pkg::IDX_BASE_PRIORITY:  rd_mux = bprio_q;
				pic_pkg::IDX_SERVICE_STATUS: rd_mux = {busy_out, 4'h0, insvc_q};
				pic_pkg::IDX_WATCHDOG_FLAGS: rd_mux = wdog_q;
				pic_pkg::IDX_EXT_ENABLE:     rd_mux = een_q;
				pic_pkg::IDX_EXT_PRIORITY:   rd_mux = eprio_q | pic_pkg::EXT_PRIO_ONES;
				default:                     rd_mux = 8'h00;
			endcase
		end
	end

	// Read data captured in the wait cycle, stands through the answer edge
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_readdata_out <= '0;
		end else if (avs_read_in && !ack_q) begin
			avs_readdata_out <= {24'h000000, rd_mux};
		end
	end

	// ==========================================================
	// Enables and priorities
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ben_q   <= 8'h00;
			een_q   <= 8'h00;
			bprio_q <= pic_pkg::PRIO_RESET;
			eprio_q <= pic_pkg::PRIO_RESET;
		end else begin
			if (wr_hit(pic_pkg::IDX_BASE_ENABLE))
				ben_q <= wdat;
			if (wr_hit(pic_pkg::IDX_EXT_ENABLE))
				een_q <= {3'b000, wdat[4:0]};
			// Upper bits unstored: read zero in base, forced ones in extended
			if (wr_hit(pic_pkg::IDX_BASE_PRIORITY))
				bprio_q <= {3'b000, wdat[4:0]};
			if (wr_hit(pic_pkg::IDX_EXT_PRIORITY))
				eprio_q <= {3'b000, wdat[4:0]};
		end
	end

	// ==========================================================
	// Pending flags; hardware set wins over any clear
	logic [7:0] timer_control_register_keep, edge_keep, ser_keep, wdog_keep;

	always_comb begin
		timer_control_register_keep = wr_hit(pic_pkg::IDX_TIMER_CONTROL) ? wdat : timer_control_register_q;
		edge_keep = wr_hit(pic_pkg::IDX_EDGE_FLAGS) ? wdat : edge_q;
		ser_keep  = wr_hit(pic_pkg::IDX_SERIAL_FLAGS) ? wdat : ser_q;
		wdog_keep = wr_hit(pic_pkg::IDX_WATCHDOG_FLAGS) ? wdat : wdog_q;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			timer_control_register_q <= 8'h00;
		end else begin
			timer_control_register_q[pic_pkg::TC_EXT0_MODE] <= timer_control_register_keep[pic_pkg::TC_EXT0_MODE];
			timer_control_register_q[pic_pkg::TC_EXT1_MODE] <= timer_control_register_keep[pic_pkg::TC_EXT1_MODE];
			// Level mode: flag mirrors the active-low pin, nothing latched
			if (!timer_control_register_q[pic_pkg::TC_EXT0_MODE])
				timer_control_register_q[pic_pkg::TC_EXT0_FLAG] <= !pin_lvl[0];
			else
				timer_control_register_q[pic_pkg::TC_EXT0_FLAG] <= pin_fall[0] ||
					(timer_control_register_keep[pic_pkg::TC_EXT0_FLAG] && !clr_src_q[pic_pkg::SRC_EXT0]);
			if (!timer_control_register_q[pic_pkg::TC_EXT1_MODE])
				timer_control_register_q[pic_pkg::TC_EXT1_FLAG] <= !pin_lvl[1];
			else
				timer_control_register_q[pic_pkg::TC_EXT1_FLAG] <= pin_fall[1] ||
					(timer_control_register_keep[pic_pkg::TC_EXT1_FLAG] && !clr_src_q[pic_pkg::SRC_EXT1]);
			timer_control_register_q[pic_pkg::TC_TMR0_FLAG] <= timer0_overflow_in ||
				(timer_control_register_keep[pic_pkg::TC_TMR0_FLAG] && !clr_src_q[pic_pkg::SRC_TMR0]);
			timer_control_register_q[pic_pkg::TC_TMR1_FLAG] <= timer1_overflow_in ||
				(timer_control_register_keep[pic_pkg::TC_TMR1_FLAG] && !clr_src_q[pic_pkg::SRC_TMR1]);
		end
	end

	// Pins 2 and 4 rising, 3 and 5 falling; no level mode exists
	logic [3:0] edge_set;
	assign edge_set = {pin_fall[5], pin_rise[4], pin_fall[3], pin_rise[2]};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_edge
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					edge_q[pic_pkg::EDGE_LSB+g] <= 1'b0;
				end else begin
					edge_q[pic_pkg::EDGE_LSB+g] <= edge_set[g] ||
						(edge_keep[pic_pkg::EDGE_LSB+g] &&
						 !clr_src_q[pic_pkg::SRC_EXT2+g]);
				end
			end
		end
	endgenerate
	assign edge_q[pic_pkg::EDGE_LSB-1:0] = '0;

	// Serial and watchdog flags are never cleared by acceptance
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ser_q  <= 8'h00;
			wdog_q <= 8'h00;
		end else begin
			ser_q[pic_pkg::SER_RX_FLAG] <= serial_receive_set_in || ser_keep[pic_pkg::SER_RX_FLAG];
			ser_q[pic_pkg::SER_TX_FLAG] <= serial_transmit_set_in || ser_keep[pic_pkg::SER_TX_FLAG];
			wdog_q[pic_pkg::WD_FLAG]    <= watchdog_event_in || wdog_keep[pic_pkg::WD_FLAG];
		end
	end

	// ==========================================================
	// Arbitration
	logic [pic_pkg::NSRC-1:0] flags, enables, prio, req_hi, req_lo;
	logic       take_aux, take_hi, take_lo, take_any;
	logic [3:0] sel;

	assign flags = {wdog_q[pic_pkg::WD_FLAG], edge_q[7:4],
		ser_q[pic_pkg::SER_RX_FLAG] || ser_q[pic_pkg::SER_TX_FLAG],
		timer_control_register_q[pic_pkg::TC_TMR1_FLAG], timer_control_register_q[pic_pkg::TC_EXT1_FLAG],
		timer_control_register_q[pic_pkg::TC_TMR0_FLAG], timer_control_register_q[pic_pkg::TC_EXT0_FLAG]};
	assign enables = {een_q[pic_pkg::PRIO_FIELD_W-1:0], ben_q[pic_pkg::PRIO_FIELD_W-1:0]} &
		{pic_pkg::NSRC{ben_q[pic_pkg::GLOBAL_GATE]}};
	assign prio   = {eprio_q[pic_pkg::PRIO_FIELD_W-1:0], bprio_q[pic_pkg::PRIO_FIELD_W-1:0]};
	assign req_hi = flags & enables & prio;
	assign req_lo = flags & enables & ~prio;

	assign take_aux = aux_request_in && !insvc_q[pic_lvl(pic_pkg::PIC_LVL_AUX)];
	assign take_hi  = (|req_hi) && !insvc_q[pic_lvl(pic_pkg::PIC_LVL_AUX)] &&
		!insvc_q[pic_lvl(pic_pkg::PIC_LVL_HIGH)];
	assign take_lo  = (|req_lo) && (insvc_q == 3'b000);
	assign take_any = instr_boundary_in && (state_q == ST_IDLE) &&
		(take_aux || take_hi || take_lo);

	function automatic int pic_lvl(input pic_pkg::pic_level_e l);
		pic_lvl = int'(l);
	endfunction : pic_lvl

	// Lowest index wins: fixed polling order
	function automatic logic [3:0] first_set(input logic [pic_pkg::NSRC-1:0] v);
		first_set = 4'h0;
		for (int k = pic_pkg::NSRC - 1; k >= 0; k--) begin
			if (v[k])
				first_set = 4'(k);
		end
	endfunction : first_set

	assign sel = take_hi ? first_set(req_hi) : first_set(req_lo);

	// ==========================================================
	// Entry and return sequencer
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q             <= ST_IDLE;
			insvc_q             <= 3'b000;
			pc_q                <= 16'h0000;
			clr_src_q           <= '0;
			stack_push_data_out <= 8'h00;
			pc_load_value_out   <= 16'h0000;
		end else begin
			clr_src_q <= '0;
			unique case (state_q)
				ST_IDLE: begin
					if (take_any) begin
						pc_q                <= pc_in;
						stack_push_data_out <= pc_in[7:0];
						state_q             <= ST_PUSH_LO;
						// Level with the highest claim wins
						if (take_aux) begin
							insvc_q[pic_lvl(pic_pkg::PIC_LVL_AUX)] <= 1'b1;
							pc_load_value_out <= pic_pkg::AUX_VECTOR;
						end else begin
							if (take_hi)
								insvc_q[pic_lvl(pic_pkg::PIC_LVL_HIGH)] <= 1'b1;
							else
								insvc_q[pic_lvl(pic_pkg::PIC_LVL_LOW)] <= 1'b1;
							pc_load_value_out <= pic_pkg::VECTOR_TABLE[32'(sel)*16 +: 16];
							clr_src_q[sel]    <= 1'b1;
						end
					end else if (return_instr_in) begin
						state_q <= ST_POP_HI;
					end
				end
				ST_PUSH_LO: begin
					stack_push_data_out <= pc_q[15:8];
					state_q             <= ST_PUSH_HI;
				end
				ST_PUSH_HI: state_q <= ST_VECTOR;
				ST_VECTOR:  state_q <= ST_IDLE;
				ST_POP_HI: begin
					pc_load_value_out[15:8] <= stack_pop_data_in;
					state_q                 <= ST_POP_LO;
				end
				ST_POP_LO: begin
					pc_load_value_out[7:0] <= stack_pop_data_in;
					state_q                <= ST_RESUME;
					// Drop the most recent, i.e. highest, level in service
					if (insvc_q[pic_lvl(pic_pkg::PIC_LVL_AUX)])
						insvc_q[pic_lvl(pic_pkg::PIC_LVL_AUX)] <= 1'b0;
					else if (insvc_q[pic_lvl(pic_pkg::PIC_LVL_HIGH)])
						insvc_q[pic_lvl(pic_pkg::PIC_LVL_HIGH)] <= 1'b0;
					else
						insvc_q[pic_lvl(pic_pkg::PIC_LVL_LOW)] <= 1'b0;
				end
				ST_RESUME: state_q <= ST_IDLE;
			endcase
		end
	end

	assign busy_out       = (state_q != ST_IDLE);
	assign stack_push_out = (state_q == ST_PUSH_LO) || (state_q == ST_PUSH_HI);
	assign stack_pop_out  = (state_q == ST_POP_HI) || (state_q == ST_POP_LO);
	assign pc_load_out    = (state_q == ST_VECTOR) || (state_q == ST_RESUME);

endmodule : pic_controller

`default_nettype wire

// ### bench/pic_controller_monitor.sv
// Port checker for the interrupt controller, bound to its top module.
// Assumes one clock domain and the controller's async high reset.
`default_nettype none

module pic_controller_monitor (
	input wire logic        ref_clk_in,          // Clock
	input wire logic        rst_in,              // Reset
	input wire logic [9:0]  avs_address_in,      // Address
	input wire logic        avs_read_in,         // Read
	input wire logic        avs_waitrequest_out, // Stall
	input wire logic [31:0] avs_readdata_out,    // Read data
	input wire logic        instr_boundary_in,   // Boundary
	input wire logic        return_instr_in,     // Return
	input wire logic [15:0] pc_in,               // PC
	input wire logic        busy_out,            // Busy
	input wire logic        stack_push_out,      // Push
	input wire logic        stack_pop_out,       // Pop
	input wire logic [7:0]  stack_push_data_out, // Push byte
	input wire logic [7:0]  stack_pop_data_in,   // Pop byte
	input wire logic        pc_load_out,         // Load
	input wire logic [15:0] pc_load_value_out    // New PC
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);
	logic rd_ack;
	assign rd_ack = avs_read_in && !avs_waitrequest_out;

	AST_PUSH_CAUSE: assert property ($rose(stack_push_out) |-> $past(instr_boundary_in))
		else $error("push without boundary");
	AST_PUSH_ORDER: assert property ($rose(stack_push_out) |->
		stack_push_data_out == $past(pc_in[7:0]) ##1
		(stack_push_out && stack_push_data_out == $past(pc_in[15:8], 2)) ##1 pc_load_out)
		else $error("push order wrong");
	AST_VEC_LEGAL: assert property (pc_load_out && $past(stack_push_out) |->
		pc_load_value_out inside {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
		16'h0033, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063})
		else $error("bad vector");
	AST_POP_CAUSE: assert property ($rose(stack_pop_out) |-> $past(return_instr_in))
		else $error("pop without return");
	AST_POP_ORDER: assert property (stack_pop_out && !$past(stack_pop_out) |=> stack_pop_out ##1
		(pc_load_out && pc_load_value_out == {$past(stack_pop_data_in, 2), $past(stack_pop_data_in)}))
		else $error("pop order wrong");
	AST_BUSY_SPAN: assert property ($rose(busy_out) |-> busy_out [*3] ##1 !busy_out)
		else $error("busy span wrong");
	AST_EXT_ONES: assert property (rd_ack && avs_address_in == {pic_pkg::IDX_EXT_PRIORITY, 2'b00} |->
		avs_readdata_out[7:5] == 3'b111)
		else $error("ext priority high bits not one");
	AST_BASE_RSVD: assert property (rd_ack && avs_address_in == {pic_pkg::IDX_BASE_PRIORITY, 2'b00} |->
		avs_readdata_out[31:5] == 27'h0)
		else $error("base priority spare bits set");
	AST_EDGE_RSVD: assert property (rd_ack && avs_address_in == {pic_pkg::IDX_EDGE_FLAGS, 2'b00} |->
		avs_readdata_out[3:0] == 4'h8)
		else $error("edge flag low bits wrong");
endmodule : pic_controller_monitor

bind pic_controller pic_controller_monitor u_mon (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_waitrequest_out(avs_waitrequest_out),
	.avs_readdata_out(avs_readdata_out), .instr_boundary_in(instr_boundary_in),
	.return_instr_in(return_instr_in), .pc_in(pc_in), .busy_out(busy_out), .stack_push_out(stack_push_out),
	.stack_pop_out(stack_pop_out), .stack_push_data_out(stack_push_data_out),
	.stack_pop_data_in(stack_pop_data_in), .pc_load_out(pc_load_out), .pc_load_value_out(pc_load_value_out));

`default_nettype wire

// ### bench/pic_core_model.sv
// Behavioural core stack answering the controller's push and pop strobes.
// Assumes push and pop never overlap; pop data is combinational.
`default_nettype none

module pic_core_model (
	input  wire logic       ref_clk_in, // Clock
	input  wire logic       push_in,    // Push strobe
	input  wire logic       pop_in,     // Pop strobe
	input  wire logic [7:0] data_in,    // Push byte
	output logic      [7:0] data_out    // Pop byte
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Stack
	logic [7:0] mem [16];
	logic [3:0] sp = 4'h0;
	always @(posedge ref_clk_in) begin
		if (push_in === 1'b1) begin
			mem[sp] <= data_in;
			sp      <= sp + 4'h1;
		end else if (pop_in === 1'b1) begin
			sp <= sp - 4'h1;
		end
	end
	// Last byte pushed comes back first; off a pop the lane is scrambled
	assign data_out = (pop_in === 1'b1) ? mem[sp - 4'h1] : ~mem[sp - 4'h1];
endmodule : pic_core_model

`default_nettype wire

// ### bench/priority_interrupt_controller_tb.sv
// Self-checking bench: register bus, sources, pins and core stack model.
// Assumes the checker is bound to the controller.
`default_nettype none

module priority_interrupt_controller_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic [9:0]  adr        = 10'h000;
	logic        rd         = 1'b0;
	logic        wr         = 1'b0;
	logic [31:0] wd         = 32'h0;
	logic [31:0] rdat;
	logic        wreq, busy, push, pop, ld;
	logic [5:0]  pins       = 6'h2b; // All inactive
	logic [4:0]  ev         = 5'h00; // wdog, tx, rx, t1, t0
	logic        aux        = 1'b0;
	logic        bnd        = 1'b0;
	logic        ret        = 1'b0;
	logic [15:0] pc         = 16'h0;
	logic [15:0] ldv;
	logic [7:0]  pdat, popd, r;
	logic [31:0] exp_rd[$];
	logic [15:0] exp_pc[$], pcs[$];
	integer      seed       = 32'h935018e7;
	int          n_errors   = 0;
	int          n_compared = 0;

	always #2 ref_clk_in = ~ref_clk_in;

	pic_controller dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h1), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wreq), .ext_request_pin_in(pins), .timer0_overflow_in(ev[0]),
		.timer1_overflow_in(ev[1]), .serial_receive_set_in(ev[2]), .serial_transmit_set_in(ev[3]),
		.watchdog_event_in(ev[4]), .aux_request_in(aux), .instr_boundary_in(bnd), .return_instr_in(ret),
		.pc_in(pc), .busy_out(busy), .stack_push_out(push), .stack_pop_out(pop),
		.stack_push_data_out(pdat), .stack_pop_data_in(popd), .pc_load_out(ld), .pc_load_value_out(ldv));
	pic_core_model u_core (.ref_clk_in(ref_clk_in), .push_in(push), .pop_in(pop), .data_in(pdat),
		.data_out(popd));

	// ==========================================================
	// Tasks
	task automatic summarize();
		if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: read expected %h got %h", $time, e, g);
		end
	endtask : cmp_rd
	task automatic cmp_pc(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: pc expected %h got %h", $time, e, g);
		end
	endtask : cmp_pc
	task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d, input logic [7:0] e);
		int i;
		if (!w) exp_rd.push_back({24'h0, e});
		@(posedge ref_clk_in);
		adr <= {idx, 2'b00};
		wd  <= {24'h0, d};
		rd  <= !w;
		wr  <= w;
		i = 0;
		// Request held until the rising edge that sees waitrequest low
		do begin
			@(posedge ref_clk_in);
			i++;
		end while (wreq !== 1'b0 && i < 20);
		if (i >= 20) begin
			n_errors++;
			summarize();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic pulse(input logic [4:0] m);
		@(posedge ref_clk_in);
		ev <= m;
		@(posedge ref_clk_in);
		ev <= 5'h00;
	endtask : pulse
	// Vector 0 means no entry expected
	task automatic enter(input logic [15:0] v);
		logic [15:0] p;
		p = $random(seed);
		if (v != 16'h0) begin
			exp_pc.push_back(v);
			pcs.push_back(p);
		end
		@(posedge ref_clk_in);
		bnd <= 1'b1;
		pc  <= p;
		@(posedge ref_clk_in);
		bnd <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
	endtask : enter
	task automatic leave();
		exp_pc.push_back(pcs.pop_back());
		@(posedge ref_clk_in);
		ret <= 1'b1;
		@(posedge ref_clk_in);
		ret <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
	endtask : leave

	// Result watcher: unexpected results compare against unknown
	always @(negedge ref_clk_in) begin
		if (rd === 1'b1 && wreq === 1'b0) cmp_rd(exp_rd.size() ? exp_rd.pop_front() : 'x, rdat);
		if (ld === 1'b1) cmp_pc(exp_pc.size() ? exp_pc.pop_front() : 'x, ldv);
	end

	initial begin
		repeat (10) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		bus(pic_pkg::IDX_BASE_PRIORITY, 0, 0, 8'h00);
		bus(pic_pkg::IDX_EXT_PRIORITY, 0, 0, 8'he0);
		bus(pic_pkg::IDX_EDGE_FLAGS, 0, 0, 8'h08);
		bus(8'h10, 0, 0, 8'h00);
		r = $random(seed);
		bus(pic_pkg::IDX_BASE_PRIORITY, 1, r, 0);
		bus(pic_pkg::IDX_BASE_PRIORITY, 0, 0, r & 8'h1f);
		bus(pic_pkg::IDX_EXT_PRIORITY, 1, r, 0);
		bus(pic_pkg::IDX_EXT_PRIORITY, 0, 0, r | 8'he0);
		bus(pic_pkg::IDX_BASE_PRIORITY, 1, 0, 0);
		bus(pic_pkg::IDX_EXT_PRIORITY, 1, 0, 0);
		bus(pic_pkg::IDX_BASE_ENABLE, 1, 8'h1f, 0);
		pulse(5'h01);
		enter(16'h0);
		bus(pic_pkg::IDX_TIMER_CONTROL, 0, 0, 8'h20);
		bus(pic_pkg::IDX_BASE_ENABLE, 1, 8'h9f, 0);
		bus(pic_pkg::IDX_TIMER_CONTROL, 1, 8'h01, 0);
		pins[0] <= 1'b0;
		repeat (16) @(posedge ref_clk_in);
		pulse(5'h0d);
		enter(16'h0003);
		leave();
		enter(16'h000b);
		leave();
		enter(16'h0023);
		leave();
		enter(16'h0023);
		leave();
		bus(pic_pkg::IDX_SERIAL_FLAGS, 1, 0, 0);
		enter(16'h0);
		pins[0] <= 1'b1;
		pulse(5'h02);
		enter(16'h001b);
		pulse(5'h01);
		enter(16'h0);
		bus(pic_pkg::IDX_EXT_PRIORITY, 1, 8'h10, 0);
		bus(pic_pkg::IDX_EXT_ENABLE, 1, 8'h10, 0);
		pulse(5'h10);
		enter(16'h0063);
		aux <= 1'b1;
		enter(16'h0033);
		enter(16'h0);
		aux <= 1'b0;
		bus(pic_pkg::IDX_WATCHDOG_FLAGS, 1, 0, 0);
		leave();
		leave();
		leave();
		enter(16'h000b);
		leave();
		bus(pic_pkg::IDX_EXT_ENABLE, 1, 8'h0f, 0);
		pins <= 6'h17;
		repeat (16) @(posedge ref_clk_in);
		bus(pic_pkg::IDX_EDGE_FLAGS, 0, 0, 8'hf8);
		bus(pic_pkg::IDX_EDGE_FLAGS, 1, 0, 0);
		pins <= 6'h2b;
		repeat (16) @(posedge ref_clk_in);
		bus(pic_pkg::IDX_EDGE_FLAGS, 0, 0, 8'h08);
		pins <= 6'h17;
		repeat (16) @(posedge ref_clk_in);
		enter(16'h0043);
		leave();
		enter(16'h004b);
		leave();
		bus(pic_pkg::IDX_EDGE_FLAGS, 0, 0, 8'hc8);
		bus(pic_pkg::IDX_EXT_ENABLE, 1, 0, 0);
		bus(pic_pkg::IDX_TIMER_CONTROL, 1, 8'h00, 0);
		pins[0] <= 1'b0; // Held through two services
		repeat (16) @(posedge ref_clk_in);
		bus(pic_pkg::IDX_TIMER_CONTROL, 0, 0, 8'h02);
		enter(16'h0003);
		leave();
		enter(16'h0003);
		leave();
		pins[0] <= 1'b1;
		repeat (16) @(posedge ref_clk_in);
		enter(16'h0);
		summarize();
	end
endmodule : priority_interrupt_controller_tb

`default_nettype wire
